//--- rtl/fbr_cfg.svh
/*
 Shared sizes and fixed latencies of the flash bus and burst read block.
 Assumes inclusion by bare name from every design file that needs it.
*/
`ifndef FBR_CFG_SVH
`define FBR_CFG_SVH
`define FBR_ADDR_W      23
`define FBR_DATA_W      16
`define FBR_BANK_W      2
`define FBR_BLK_W       6
`define FBR_SUB_W       4
`define FBR_BLK_WAIT    2'd2
`define FBR_ODD_WAIT    2'd1
`define FBR_WAIT_W      4
`define FBR_BUF_DEPTH   2
`endif

//--- rtl/fbr_pkg.sv
/*
 Types of the flash bus and burst read block.
 Assumes nothing of its surroundings.
*/
package fbr_pkg;
   typedef enum logic [1:0] {
      FBR_CONT   = 2'b00,
      FBR_WRAP8  = 2'b01,
      FBR_WRAP16 = 2'b10,
      FBR_WRAP32 = 2'b11
   } fbr_mode_type;

   typedef enum logic [1:0] {
      FBR_IDLE  = 2'b00,
      FBR_INIT  = 2'b01,
      FBR_BURST = 2'b11,
      FBR_STAT  = 2'b10
   } fbr_state_type;
endpackage

//--- rtl/fbr_stream_if.sv
/*
 Valid/ready word stream between the block's own modules.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
interface fbr_stream_if #(parameter int W = 16);
   logic         valid;
   logic         ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface // fbr_stream_if

//--- rtl/fbr_buf.sv
/*
 Small flip-flop FIFO for read words headed to the data pins.
 Assumes a synchronous active-high reset and a flush that empties it.
*/
`timescale 1ns/100ps
`include "fbr_cfg.svh"
module fbr_buf #(
   parameter int W     = `FBR_DATA_W,
   parameter int DEPTH = `FBR_BUF_DEPTH
) (
   // Clock and reset
   input  wire logic    clk_i,
   input  wire logic    rst_i,
   input  wire logic    flush_i,
   // Streams
   fbr_stream_if.snk    in_s,
   fbr_stream_if.src    out_s
);
   localparam int PW = $clog2(DEPTH);
   logic [W-1:0]  mem [DEPTH];
   logic [PW-1:0] wr_ptr;
   logic [PW-1:0] rd_ptr;
   logic [PW:0]   count;
   logic          push;
   logic          pop;

   assign in_s.ready  = (count != (PW+1)'(DEPTH));
   assign out_s.valid = (count != '0);
   assign out_s.data  = mem[rd_ptr];
   assign push        = in_s.valid & in_s.ready;
   assign pop         = out_s.valid & out_s.ready;

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr] <= in_s.data;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || flush_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + (PW+1)'(push) - (PW+1)'(pop);
      end
   end
endmodule // fbr_buf

//--- rtl/fbr_step.sv
/*
 Next burst address and the boundary wait states it costs.
 Assumes a pure combinational use by the burst sequencer.
*/
`timescale 1ns/100ps
`include "fbr_cfg.svh"
module fbr_step #(
   parameter int AW = `FBR_ADDR_W
) (
   // Step request
   input  fbr_pkg::fbr_mode_type mode_i,
   input  wire logic [AW-1:0]    addr_i,
   input  wire logic             odd_pend_i,
   // Step result
   output logic [AW-1:0]         next_addr_o,
   output logic [1:0]            extra_o,
   output logic                  bank_cross_o
);
   import fbr_pkg::*;
   logic [AW-1:0] inc;

   always_comb begin
      inc          = addr_i + 1'b1;
      next_addr_o  = inc;
      extra_o      = 2'd0;
      bank_cross_o = 1'b0;
      unique case (mode_i)
         FBR_CONT: begin
            next_addr_o = inc;
            if (inc[`FBR_BLK_W-1:0] == '0) begin
               extra_o      = `FBR_BLK_WAIT;
               bank_cross_o = inc[AW-1 -: `FBR_BANK_W] != addr_i[AW-1 -: `FBR_BANK_W];
            end
            if (odd_pend_i && inc[`FBR_SUB_W-1:0] == '0) begin
               extra_o = extra_o + `FBR_ODD_WAIT;
            end
         end
         FBR_WRAP8:  next_addr_o = {addr_i[AW-1:3], inc[2:0]};
         FBR_WRAP16: next_addr_o = {addr_i[AW-1:4], inc[3:0]};
         FBR_WRAP32: next_addr_o = {addr_i[AW-1:5], inc[4:0]};
      endcase
   end
endmodule // fbr_step

//--- rtl/fbr_flash_bus.sv
/*
 Device-side bus interface of a burst NOR flash: pin decode, command
 latches, asynchronous and synchronous burst reads with ready.
 Assumes host pins are asynchronous to ref_clk_i and the burst clock is
 well below a third of it; array data returns one cycle after a read.
*/
`timescale 1ns/100ps
`include "fbr_cfg.svh"
module fbr_flash_bus #(
   parameter int AW = `FBR_ADDR_W,
   parameter int DW = `FBR_DATA_W,
   parameter int WW = `FBR_WAIT_W
) (
   // Clock and reset
   input  wire logic             ref_clk_i,
   input  wire logic             sys_rst_i,
   // Flash pins
   input  wire logic             chip_sel_n_i,
   input  wire logic             out_en_n_i,
   input  wire logic             write_n_i,
   input  wire logic             address_valid_strobe_n_i,
   input  wire logic             hw_rst_n_i,
   input  wire logic             burst_clk_i,
   input  wire logic [AW-1:0]    address_bus_i,
   input  wire logic [DW-1:0]    data_bus_i,
   output logic [DW-1:0]         data_bus_o,
   output logic                  data_bus_oe_o,
   output logic                  rdy_o,
   output logic                  rdy_oe_o,
   // Configuration
   input  wire logic             cfg_set_i,
   input  fbr_pkg::fbr_mode_type cfg_mode_i,
   input  wire logic [WW-1:0]    cfg_wait_i,
   input  wire logic             cfg_falling_edge_i,
   output logic                  sync_mode_o,
   // Array and command side
   output logic                  arr_rd_o,
   output logic [AW-1:0]         arr_addr_o,
   input  wire logic [DW-1:0]    arr_data_i,
   input  wire logic [3:0]       bank_busy_i,
   input  wire logic [DW-1:0]    status_data_i,
   output logic                  cmd_valid_o,
   output logic [AW-1:0]         cmd_addr_o,
   output logic [DW-1:0]         cmd_data_o
);
   import fbr_pkg::*;
   localparam int PW = 6 + AW + DW;
   // Pins reset to their idle levels; the burst clock idles low
   localparam logic [PW-1:0] PIN_IDLE = ~(PW'(1) << 5);

   logic [PW-1:0]   pin_meta;
   logic [PW-1:0]   pin_s;
   logic            ce_n, oe_n, we_n, avd_n, hw_n, bclk;
   logic [AW-1:0]   addr_in;
   logic [DW-1:0]   data_in;
   logic            avd_q, bclk_q, wr_q, rd_q;
   logic            rst_all, avd_rise, bclk_edge, take, go, wr_act;
   fbr_mode_type    mode_q;
   logic [WW-1:0]   wait_q;
   logic            fall_q;
   fbr_state_type   state;
   logic [AW-1:0]   cur;
   logic [1:0]      pend;
   logic            odd_pend;
   logic [WW-1:0]   init_cnt;
   logic            edge_pend;
   logic [AW-1:0]   step_next;
   logic [1:0]      step_extra;
   logic            step_bank;

   fbr_stream_if #(.W(DW)) rd_in ();
   fbr_stream_if #(.W(DW)) rd_out ();

   // Two-stage synchronisers on every host pin
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         pin_meta <= PIN_IDLE;
         pin_s    <= PIN_IDLE;
      end else begin
         pin_meta <= {data_bus_i, address_bus_i, burst_clk_i, hw_rst_n_i,
                      address_valid_strobe_n_i, write_n_i, out_en_n_i, chip_sel_n_i};
         pin_s    <= pin_meta;
      end
   end

   assign {data_in, addr_in, bclk, hw_n, avd_n, we_n, oe_n, ce_n} = pin_s;
   assign rst_all   = sys_rst_i | ~hw_n;
   assign bclk_edge = fall_q ? (bclk_q & ~bclk) : (~bclk_q & bclk);
   assign avd_rise  = ~avd_q & avd_n & ~ce_n & we_n;
   assign take      = edge_pend | bclk_edge;
   assign go        = take & ~oe_n & we_n & avd_n & rd_in.ready;
   assign wr_act    = ~ce_n & ~we_n & oe_n;

   always_ff @(posedge ref_clk_i) begin
      if (rst_all) begin
         avd_q  <= 1'b1;
         bclk_q <= 1'b0;
         wr_q   <= 1'b0;
         rd_q   <= 1'b0;
      end else begin
         avd_q  <= avd_n;
         bclk_q <= bclk;
         wr_q   <= wr_act;
         rd_q   <= arr_rd_o;
      end
   end

   // Read mode and burst settings change only by the configuration command or a reset
   always_ff @(posedge ref_clk_i) begin
      if (rst_all) begin
         sync_mode_o <= 1'b0;
         mode_q      <= FBR_CONT;
         wait_q      <= '0;
         fall_q      <= 1'b0;
      end else if (cfg_set_i) begin
         sync_mode_o <= 1'b1;
         mode_q      <= cfg_mode_i;
         wait_q      <= cfg_wait_i;
         fall_q      <= cfg_falling_edge_i;
      end
   end

   // Command latches
   always_ff @(posedge ref_clk_i) begin
      if (rst_all) begin
         cmd_valid_o <= 1'b0;
         cmd_addr_o  <= '0;
         cmd_data_o  <= '0;
      end else begin
         cmd_valid_o <= wr_q & ~wr_act;
         if (wr_act && !wr_q) begin
            cmd_addr_o <= addr_in;
         end
         if (wr_q && !wr_act) begin
            cmd_data_o <= data_in;
         end
      end
   end

   fbr_step #(.AW(AW)) u_step (
      .mode_i       (mode_q),
      .addr_i       (cur),
      .odd_pend_i   (odd_pend),
      .next_addr_o  (step_next),
      .extra_o      (step_extra),
      .bank_cross_o (step_bank)
   );

   // Burst sequencer
   always_ff @(posedge ref_clk_i) begin
      if (rst_all) begin
         state     <= FBR_IDLE;
         cur       <= '0;
         pend      <= 2'd0;
         odd_pend  <= 1'b0;
         init_cnt  <= '0;
         edge_pend <= 1'b0;
         rdy_o     <= 1'b0;
         arr_rd_o  <= 1'b0;
         arr_addr_o <= '0;
      end else begin
         arr_rd_o  <= 1'b0;
         edge_pend <= take & ~go;
         if (ce_n) begin
            state     <= FBR_IDLE;
            edge_pend <= 1'b0;
            rdy_o     <= 1'b0;
         end else if (avd_rise) begin
            cur       <= addr_in;
            odd_pend  <= addr_in[0];
            pend      <= 2'd0;
            edge_pend <= 1'b0;
            rdy_o     <= 1'b0;
            if (sync_mode_o) begin
               state    <= FBR_INIT;
               init_cnt <= wait_q;
            end else begin
               state      <= FBR_IDLE;
               arr_rd_o   <= 1'b1;
               arr_addr_o <= addr_in;
            end
         end else begin
            unique case (state)
               FBR_IDLE: ;
               FBR_STAT: ;
               FBR_INIT: begin
                  if (go) begin
                     if (init_cnt == '0) begin
                        state      <= FBR_BURST;
                        arr_rd_o   <= 1'b1;
                        arr_addr_o <= cur;
                        rdy_o      <= 1'b1;
                     end else begin
                        init_cnt <= init_cnt - 1'b1;
                     end
                  end
               end
               FBR_BURST: begin
                  if (go && pend != 2'd0) begin
                     pend <= pend - 1'b1;
                     rdy_o <= (pend == 2'd1);
                     if (pend == 2'd1) begin
                        arr_rd_o   <= 1'b1;
                        arr_addr_o <= cur;
                     end
                  end else if (go) begin
                     cur <= step_next;
                     if (step_next[`FBR_SUB_W-1:0] == '0) begin
                        odd_pend <= 1'b0;
                     end
                     if (step_bank && bank_busy_i[step_next[AW-1 -: `FBR_BANK_W]]) begin
                        state <= FBR_STAT;
                        rdy_o <= 1'b0;
                     end else if (step_extra != 2'd0) begin
                        pend  <= step_extra;
                        rdy_o <= 1'b0;
                     end else begin
                        arr_rd_o   <= 1'b1;
                        arr_addr_o <= step_next;
                        rdy_o      <= 1'b1;
                     end
                  end
               end
            endcase
         end
      end
   end

   assign rd_in.valid  = rd_q;
   assign rd_in.data   = arr_data_i;
   assign rd_out.ready = ~oe_n;

   fbr_buf #(.W(DW), .DEPTH(`FBR_BUF_DEPTH)) u_buf (
      .clk_i   (ref_clk_i),
      .rst_i   (rst_all),
      .flush_i (ce_n | avd_rise),
      .in_s    (rd_in.snk),
      .out_s   (rd_out.src)
   );

   // Pin drivers
   always_ff @(posedge ref_clk_i) begin
      if (rst_all) begin
         data_bus_o    <= '0;
         data_bus_oe_o <= 1'b0;
         rdy_oe_o      <= 1'b0;
      end else begin
         data_bus_oe_o <= ~ce_n & ~oe_n & we_n;
         rdy_oe_o      <= sync_mode_o & ~ce_n;
         if (state == FBR_STAT) begin
            data_bus_o <= status_data_i;
         end else if (rd_out.valid && rd_out.ready) begin
            data_bus_o <= rd_out.data;
         end
      end
   end

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_all);

   a_cmd_data_latch: assert property ((wr_q && !wr_act) |=> cmd_valid_o && cmd_data_o == $past(data_in))
      else $error("command data not latched");
   a_async_read: assert property ((avd_rise && !sync_mode_o) |=> arr_rd_o && arr_addr_o == $past(addr_in))
      else $error("async read not issued");
   a_mode_hold: assert property ((sync_mode_o && !cfg_set_i) |=> sync_mode_o)
      else $error("read mode changed without command");
   a_reset_async: assert property (disable iff (sys_rst_i) !hw_n |=> !sync_mode_o && !data_bus_oe_o && state == FBR_IDLE)
      else $error("hardware reset did not restore async read");
   a_sync_only: assert property ((avd_rise && sync_mode_o) |=> state == FBR_INIT && !arr_rd_o)
      else $error("sync mode issued an async read");
   a_first_word: assert property ((state == FBR_INIT && go && init_cnt == '0 && !avd_rise && !ce_n) |=> arr_rd_o && rdy_o)
      else $error("first burst word missing");
   a_block_wait: assert property ((state == FBR_BURST && go && pend == 2'd0 && !avd_rise && mode_q == FBR_CONT
      && !ce_n && step_next[`FBR_BLK_W-1:0] == '0 && !step_bank)
      |=> pend == ($past(odd_pend) ? 2'd3 : 2'd2) && !rdy_o)
      else $error("block boundary wait wrong");
   a_odd_wait: assert property ((state == FBR_BURST && go && pend == 2'd0 && !avd_rise && !ce_n && mode_q == FBR_CONT
      && odd_pend && step_next[`FBR_SUB_W-1:0] == '0 && step_next[`FBR_BLK_W-1:`FBR_SUB_W] != '0)
      |=> pend == 2'd1 && !rdy_o && !odd_pend)
      else $error("odd start wait wrong");
   a_wait_rdy_low: assert property ((state == FBR_BURST && pend == 2'd2 && !ce_n && !avd_rise) |=> !rdy_o)
      else $error("ready high during inserted latency");
   a_busy_bank: assert property ((state == FBR_BURST && go && pend == 2'd0 && !avd_rise && !ce_n && step_bank
      && bank_busy_i[step_next[AW-1 -: `FBR_BANK_W]])
      |=> state == FBR_STAT ##1 (state == FBR_STAT || $past(ce_n) || $past(avd_rise)))
      else $error("busy bank crossing not handled");
   a_linear_group: assert property ((state == FBR_BURST && mode_q != FBR_CONT && !avd_rise && !ce_n)
      |=> $stable(cur[AW-1:5]) && pend == 2'd0)
      else $error("linear burst left its group");
   a_standby: assert property (ce_n |=> state == FBR_IDLE && !data_bus_oe_o ##1 (!data_bus_oe_o || !$past(ce_n)))
      else $error("standby not entered");

   c_burst_start: cover property (state == FBR_INIT ##[1:200] state == FBR_BURST);
   c_block_cross: cover property (state == FBR_BURST && pend == 2'd3);
   c_status_read: cover property (state == FBR_STAT);
   c_cmd_write:   cover property (cmd_valid_o);
endmodule // fbr_flash_bus

//--- sim/fbr_host_model.sv
/*
 Host model of the flash bus: drives select, enables, strobes, reset,
 burst clock, address and data pins through tasks.
 Assumes a free-running reference clock and calls from one process.
*/
`timescale 1ns/100ps
module fbr_host_model (
   // Clock
   input  wire logic   ref_clk_i,
   // Flash pins
   output logic        chip_sel_n_o,
   output logic        out_en_n_o,
   output logic        write_n_o,
   output logic        address_valid_strobe_n_o,
   output logic        hw_rst_n_o,
   output logic        burst_clk_o,
   output logic [22:0] address_bus_o,
   output logic [15:0] data_bus_o
);
   initial begin
      chip_sel_n_o             = 1'b1;
      out_en_n_o               = 1'b1;
      write_n_o                = 1'b1;
      address_valid_strobe_n_o = 1'b1;
      hw_rst_n_o               = 1'b1;
      burst_clk_o              = 1'b0;
      address_bus_o            = 23'h00_0000;
      data_bus_o               = 16'h0000;
   end

   task automatic clks(input int n);
      repeat (n) @(posedge ref_clk_i);
   endtask

   task automatic load(input logic [22:0] a);
      @(posedge ref_clk_i);
      chip_sel_n_o             <= 1'b0;
      write_n_o                <= 1'b1;
      out_en_n_o               <= 1'b0;
      address_valid_strobe_n_o <= 1'b0;
      address_bus_o            <= a;
      clks(4);
      address_valid_strobe_n_o <= 1'b1;
      clks(4);
      // Released bus shows the inverse, not the last value
      address_bus_o            <= ~a;
   endtask

   task automatic write(input logic [22:0] a, input logic [15:0] d);
      @(posedge ref_clk_i);
      chip_sel_n_o  <= 1'b0;
      out_en_n_o    <= 1'b1;
      address_bus_o <= a;
      data_bus_o    <= d;
      write_n_o     <= 1'b0;
      clks(4);
      write_n_o     <= 1'b1;
      clks(4);
      address_bus_o <= ~a;
      data_bus_o    <= ~d;
   endtask

   // One burst clock period; edges spaced well apart for the synchronisers
   task automatic tick();
      @(posedge ref_clk_i);
      burst_clk_o <= 1'b1;
      clks(8);
      burst_clk_o <= 1'b0;
      clks(8);
   endtask

   task automatic deselect();
      @(posedge ref_clk_i);
      chip_sel_n_o <= 1'b1;
      out_en_n_o   <= 1'b1;
      clks(6);
   endtask

   task automatic set_rst(input logic v);
      @(posedge ref_clk_i);
      hw_rst_n_o <= v;
      clks(6);
   endtask
endmodule // fbr_host_model

//--- sim/test_flash_bus_and_burst_read.sv
/*
 Self-checking bench of the flash bus and burst read block.
 Assumes the host model drives the pins and a small array model answers reads.
*/
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module test_flash_bus_and_burst_read;
   import fbr_pkg::*;
   localparam logic [15:0] STATUS = 16'h00C3;
   typedef struct {fbr_mode_type m; logic f; logic [22:0] a; int n;} fbr_row_type;
   logic         ref_clk     = 1'b0;
   logic         sys_rst     = 1'b1;
   logic         cs_n, oe_n, we_n, address_valid_strobe_n, hw_rst_n, burst_clk;
   logic [22:0]  address_bus, arr_addr, cmd_addr;
   logic [15:0]  data_in, data_out, cmd_data;
   logic [15:0]  arr_data    = 16'h0000;
   logic         cfg_set     = 1'b0;
   fbr_mode_type cfg_mode    = FBR_CONT;
   logic         cfg_edge    = 1'b0;
   logic [3:0]   bank_busy   = 4'h0;
   logic [3:0]   cfg_wait    = 4'h0;
   logic [15:0]  status_word = 16'h0000;
   int           n_rd        = 0;
   logic         data_oe, rdy, rdy_oe, sync_mode, arr_rd, cmd_valid;
   int           n_errors    = 0;
   int           compares    = 0;
   int           n_cmd       = 0;
   fbr_row_type  rows [8]    = '{'{FBR_CONT, 1'b0, 23'h00_003C, 6}, '{FBR_CONT, 1'b1, 23'h00_001B, 24},
                                 '{FBR_CONT, 1'b0, 23'h00_003D, 5}, '{FBR_CONT, 1'b0, 23'h1F_FFFE, 4},
                                 '{FBR_CONT, 1'b0, 23'h7F_FFFE, 4}, '{FBR_WRAP8, 1'b0, 23'h00_0039, 10},
                                 '{FBR_WRAP16, 1'b1, 23'h00_003D, 18}, '{FBR_WRAP32, 1'b0, 23'h00_0025, 34}};

   initial begin
      forever #25 ref_clk = ~ref_clk;
   end

   function automatic logic [15:0] word(input logic [22:0] a);
      return a[15:0] ^ {9'h000, a[22:16]};
   endfunction

   function automatic logic [22:0] step(input fbr_mode_type m, input logic [22:0] a);
      logic [22:0] g;
      g = (m == FBR_WRAP8) ? 23'h00_0007 : (m == FBR_WRAP16) ? 23'h00_000F :
          (m == FBR_WRAP32) ? 23'h00_001F : 23'h7F_FFFF;
      return (a & ~g) | ((a + 23'h00_0001) & g);
   endfunction

   // Array answers the cycle after a read strobe
   always @(posedge ref_clk) begin
      arr_data <= word(arr_addr);
      if (cmd_valid === 1'b1)
         n_cmd <= n_cmd + 1;
      if (arr_rd === 1'b1)
         n_rd <= n_rd + 1;
   end

   fbr_host_model i_host (
      .ref_clk_i                (ref_clk),
      .chip_sel_n_o             (cs_n),
      .out_en_n_o               (oe_n),
      .write_n_o                (we_n),
      .address_valid_strobe_n_o (address_valid_strobe_n),
      .hw_rst_n_o               (hw_rst_n),
      .burst_clk_o              (burst_clk),
      .address_bus_o            (address_bus),
      .data_bus_o               (data_in)
   );

   fbr_flash_bus i_dut (
      .ref_clk_i                (ref_clk),
      .sys_rst_i                (sys_rst),
      .chip_sel_n_i             (cs_n),
      .out_en_n_i               (oe_n),
      .write_n_i                (we_n),
      .address_valid_strobe_n_i (address_valid_strobe_n),
      .hw_rst_n_i               (hw_rst_n),
      .burst_clk_i              (burst_clk),
      .address_bus_i            (address_bus),
      .data_bus_i               (data_in),
      .data_bus_o               (data_out),
      .data_bus_oe_o            (data_oe),
      .rdy_o                    (rdy),
      .rdy_oe_o                 (rdy_oe),
      .cfg_set_i                (cfg_set),
      .cfg_mode_i               (cfg_mode),
      .cfg_wait_i               (cfg_wait),
      .cfg_falling_edge_i       (cfg_edge),
      .sync_mode_o              (sync_mode),
      .arr_rd_o                 (arr_rd),
      .arr_addr_o               (arr_addr),
      .arr_data_i               (arr_data),
      .bank_busy_i              (bank_busy),
      .status_data_i            (status_word),
      .cmd_valid_o              (cmd_valid),
      .cmd_addr_o               (cmd_addr),
      .cmd_data_o               (cmd_data)
   );

   task automatic cfg(input fbr_mode_type m, input logic f, input logic [3:0] w);
      @(posedge ref_clk);
      cfg_set  <= 1'b1;
      cfg_mode <= m;
      cfg_edge <= f;
      cfg_wait <= w;
      @(posedge ref_clk);
      cfg_set  <= 1'b0;
      @(negedge ref_clk);
      `CHK(sync_mode, 1'b1)
   endtask

   task automatic async_read(input logic [22:0] a);
      int r0;
      r0 = n_rd;
      i_host.load(a);
      i_host.clks(4);
      @(negedge ref_clk);
      `CHK(n_rd - r0, 1)
      `CHK(arr_addr, a)
      `CHK(data_out, word(a))
      `CHK(data_oe, 1'b1)
      `CHK(rdy_oe, 1'b0)
      $display("test async read done");
   endtask

   task automatic run_row(input fbr_row_type r);
      logic [22:0] a;
      logic        odd;
      int          w;
      logic        q_r [$];
      logic [22:0] q_a [$];
      logic [3:0]  iw;
      int          r0;
      a   = r.a;
      odd = r.a[0];
      iw  = r.f ? 4'h3 : 4'h2;
      repeat (iw) begin
         q_r.push_back(1'b0);
         q_a.push_back(a);
      end
      for (int i = 0; i < r.n; i++) begin
         if (i > 0) begin
            a = step(r.m, a);
            w = (r.m == FBR_CONT && a[5:0] == 6'h00) ? 2 : 0;
            if (r.m == FBR_CONT && odd && a[3:0] == 4'h0) begin
               w++;
               odd = 1'b0;
            end
            repeat (w) begin
               q_r.push_back(1'b0);
               q_a.push_back(a);
            end
         end
         q_r.push_back(1'b1);
         q_a.push_back(a);
      end
      cfg(r.m, r.f, iw);
      r0 = n_rd;
      i_host.load(r.a);
      foreach (q_r[k]) begin
         i_host.tick();
         @(negedge ref_clk);
         `CHK(rdy, q_r[k])
         if (q_r[k])
            `CHK(data_out, word(q_a[k]))
      end
      `CHK(n_rd - r0, r.n)
      i_host.deselect();
      $display("test burst row at %h done", r.a);
   endtask

   task automatic summarize();
      $display("compares=%0d n_errors=%0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (3) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(negedge ref_clk);
      `CHK(data_oe, 1'b0)
      `CHK(sync_mode, 1'b0)
      `CHK(cmd_valid, 1'b0)
      $display("test reset done");
      i_host.write(23'h00_0555, 16'h00AA);
      @(negedge ref_clk);
      `CHK(cmd_addr, 23'h00_0555)
      `CHK(cmd_data, 16'h00AA)
      `CHK(n_cmd, 1)
      `CHK(data_oe, 1'b0)
      $display("test write done");
      async_read(23'h12_3456);
      foreach (rows[i])
         run_row(rows[i]);
      cfg(FBR_CONT, 1'b0, 4'h2);
      @(posedge ref_clk);
      bank_busy   <= 4'b0010;
      status_word <= STATUS;
      i_host.load(23'h1F_FFFE);
      repeat (6) i_host.tick();
      @(negedge ref_clk);
      `CHK(data_out, STATUS)
      i_host.tick();
      @(negedge ref_clk);
      `CHK(data_out, STATUS)
      bank_busy <= 4'h0;
      i_host.deselect();
      @(negedge ref_clk);
      `CHK(data_oe, 1'b0)
      `CHK(rdy_oe, 1'b0)
      $display("test busy bank and standby done");
      i_host.load(23'h00_0040);
      repeat (3) i_host.tick();
      i_host.set_rst(1'b0);
      @(negedge ref_clk);
      `CHK(data_oe, 1'b0)
      `CHK(sync_mode, 1'b0)
      i_host.set_rst(1'b1);
      $display("test hardware reset done");
      async_read(23'h00_0077);
      summarize();
   end

   initial begin
      repeat (20000) @(posedge ref_clk);
      n_errors++;
      $display("watchdog expired");
      summarize();
   end
endmodule // test_flash_bus_and_burst_read
